/* rtl/viu_defines.vh */
// constants for the vectored interrupt unit
`ifndef VIU_DEFINES_VH
`define VIU_DEFINES_VH
// register addresses on the local register port
`define VIU_ADDR_SLM      8'h00_F5
`define VIU_ADDR_PRA      8'h00_F6
`define VIU_ADDR_IERC     8'h00_FE
`define VIU_ADDR_ISTAT    8'h00_E6
`define VIU_ADDR_IMASK    8'h00_E7
`define VIU_ADDR_ACK      8'h00_E4
// serial link mode fields
`define VIU_SLM_SEL_LO    2
`define VIU_SLM_SEL_HI    3
`define VIU_SLM_WIDTH     6
`define VIU_SEL_TIMER2    2'h0
`define VIU_SEL_SERIAL    2'h1
// peripheral register area edge bits
`define VIU_PRA_EDGE_A    4
`define VIU_PRA_EDGE_B    5
// control register layout: enables in 3:0 plus 4, requests above
`define VIU_IE_A          0
`define VIU_IE_TX         1
`define VIU_IE_T1         2
`define VIU_IE_T2         3
`define VIU_IE_B          4
`define VIU_NSRC          5
// source index in priority order (0 = best maskable)
`define VIU_SRC_A         3'h0
`define VIU_SRC_TX        3'h1
`define VIU_SRC_T1        3'h2
`define VIU_SRC_T2        3'h3
`define VIU_SRC_B         3'h4
`define VIU_SRC_NONE      3'h7
// vector addresses (low byte of each pair)
`define VIU_VEC_RESET     16'hFF_FE
`define VIU_VEC_A         16'hFF_FC
`define VIU_VEC_TX        16'hFF_FA
`define VIU_VEC_T1        16'hFF_F8
`define VIU_VEC_T2        16'hFF_F6
`define VIU_VEC_B         16'hFF_F4
`endif

/* rtl/viu_edge_det.v */
// selectable edge detector for one external interrupt pin
`timescale 1ns/1ns
`default_nettype none
module viu_edge_det (
    input  wire clk_sys,
    input  wire rst,
    input  wire pin_in,
    input  wire rise_sel,
    output wire edge_evt
);
    reg pin_d_r;

    // previous pin level; reset to idle-high so no false fall at start
    always @(posedge clk_sys) begin
        if (rst) begin
            pin_d_r <= 1'b1;
        end else begin
            pin_d_r <= pin_in;
        end
    end

    // 0 picks falling, 1 picks rising
    assign edge_evt = rise_sel ? (pin_in & ~pin_d_r) : (~pin_in & pin_d_r);
endmodule
`default_nettype wire

/* rtl/viu_top.v */
// vectored interrupt unit: requests, enables, priority and vector hand-off
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
`include "viu_defines.vh"
module viu_top #(
    parameter AW = 8,
    parameter DW = 8
) (
    input  wire          clk_sys,
    input  wire          rst,
    // register port
    input  wire [AW-1:0] reg_addr,
    input  wire [DW-1:0] reg_wdata,
    input  wire          reg_wr,
    input  wire          reg_rd,
    output reg  [DW-1:0] reg_rdata,
    // request sources
    input  wire          ext_irq_a,
    input  wire          ext_irq_b,
    input  wire          timer_x_zero,
    input  wire          timer_1_zero,
    input  wire          timer_2_zero,
    input  wire          serial_cnt_zero,
    input  wire          software_break_op,
    // core handshake
    input  wire          core_disable_flag,
    input  wire          core_ack,
    output wire          core_irq,
    output reg  [15:0]   core_vector,
    output reg           core_is_reset,
    output reg           core_is_break,
    output reg           core_push,
    output reg           core_set_disable,
    // pin sharing
    output wire          port_three_serial,
    // system interrupt
    output wire          irq_out
);
    reg [`VIU_SLM_WIDTH-1:0] slm_r;
    reg [DW-1:0]             pra_r;
    reg [`VIU_NSRC-1:0]      ien_r;
    reg [`VIU_NSRC-1:0]      ireq_r;
    reg [`VIU_NSRC-1:0]      ireq_nxt;
    reg                      brk_pend_r;
    reg                      rst_pend_r;
    reg [3:0]                istat_r;
    reg [3:0]                istat_nxt;
    reg [3:0]                imask_r;
    reg [2:0]                src_sel;
    reg [`VIU_NSRC-1:0]      evt;
    wire                     evt_a;
    wire                     evt_b;
    wire [1:0]               link_sel;
    wire                     src5_zero;
    wire [`VIU_NSRC-1:0]     eligible;
    wire                     accept;

    // fixed priority encoder, lowest index wins
    function [2:0] prio_pick;
        input [`VIU_NSRC-1:0] vec;
        integer i;
        begin
            prio_pick = `VIU_SRC_NONE;
            for (i = `VIU_NSRC - 1; i >= 0; i = i - 1) begin
                if (vec[i]) begin
                    prio_pick = i[2:0];
                end
            end
        end
    endfunction

    // vector address of a maskable source
    function [15:0] vec_of;
        input [2:0] s;
        begin
            case (s)
                `VIU_SRC_A:  vec_of = `VIU_VEC_A;
                `VIU_SRC_TX: vec_of = `VIU_VEC_TX;
                `VIU_SRC_T1: vec_of = `VIU_VEC_T1;
                `VIU_SRC_T2: vec_of = `VIU_VEC_T2;
                `VIU_SRC_B:  vec_of = `VIU_VEC_B;
                default:     vec_of = `VIU_VEC_RESET;
            endcase
        end
    endfunction

    // pin edge detection, polarity from area bits 4 and 5
    viu_edge_det u_edge_a (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .pin_in   (ext_irq_a),
        .rise_sel (pra_r[`VIU_PRA_EDGE_A]),
        .edge_evt (evt_a)
    );

    viu_edge_det u_edge_b (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .pin_in   (ext_irq_b),
        .rise_sel (pra_r[`VIU_PRA_EDGE_B]),
        .edge_evt (evt_b)
    );

    // fifth source routed by link mode bits 3:2
    assign link_sel  = slm_r[`VIU_SLM_SEL_HI:`VIU_SLM_SEL_LO];
    assign src5_zero = (link_sel == `VIU_SEL_SERIAL) ? serial_cnt_zero
                     : (link_sel == `VIU_SEL_TIMER2) ? timer_2_zero : 1'b0;
    assign port_three_serial = (link_sel == `VIU_SEL_SERIAL);

    // hardware request events
    always @* begin
        evt = {`VIU_NSRC{1'b0}};
        evt[`VIU_SRC_A]  = evt_a;
        evt[`VIU_SRC_TX] = timer_x_zero;
        evt[`VIU_SRC_T1] = timer_1_zero;
        evt[`VIU_SRC_T2] = src5_zero;
        evt[`VIU_SRC_B]  = evt_b;
    end

    // eligible sources: enable and request, gated by disable flag
    assign eligible = (ien_r & ireq_r) & {`VIU_NSRC{~core_disable_flag}};
    always @* begin
        src_sel = prio_pick(eligible);
    end

    // reset beats everything and ignores the disable flag
    assign core_irq = rst_pend_r | brk_pend_r | (src_sel != `VIU_SRC_NONE);
    assign accept   = core_ack & core_irq;

    // request bits: events set, software may only clear, accept clears one
    always @* begin
        ireq_nxt = ireq_r;
        if (reg_wr && reg_addr == `VIU_ADDR_IERC) begin
            // requests live in the high bits of the written byte; timer 1 shares bit 4
            ireq_nxt = ireq_r & {reg_wdata[DW-1], reg_wdata[DW-2], reg_wdata[DW-4],
                                 reg_wdata[DW-3], reg_wdata[DW-4]};
        end
        // a pending break must not keep the serviced source's request alive
        if (accept && !rst_pend_r && src_sel != `VIU_SRC_NONE) begin
            ireq_nxt[src_sel] = 1'b0;
        end
        ireq_nxt = ireq_nxt | evt; // set wins over any clear
    end

    // status bits for the system interrupt: pending, accept, break, reset taken
    always @* begin
        istat_nxt = istat_r;
        if (reg_rd && reg_addr == `VIU_ADDR_ISTAT) begin
            istat_nxt = 4'h0;
        end
        istat_nxt[0] = istat_nxt[0] | (|evt);
        istat_nxt[1] = istat_nxt[1] | accept;
        istat_nxt[2] = istat_nxt[2] | software_break_op;
        istat_nxt[3] = istat_nxt[3] | (accept & rst_pend_r);
    end
    assign irq_out = |(istat_r & imask_r);

    // registers and acceptance sequencing
    always @(posedge clk_sys) begin
        if (rst) begin
            slm_r            <= {`VIU_SLM_WIDTH{1'b0}};
            pra_r            <= {DW{1'b0}};
            ien_r            <= {`VIU_NSRC{1'b0}};
            ireq_r           <= {`VIU_NSRC{1'b0}};
            brk_pend_r       <= 1'b0;
            rst_pend_r       <= 1'b1;   // reset is served as the first interrupt
            istat_r          <= 4'h0;
            imask_r          <= 4'h0;
            core_vector      <= `VIU_VEC_RESET;
            core_is_reset    <= 1'b0;
            core_is_break    <= 1'b0;
            core_push        <= 1'b0;
            core_set_disable <= 1'b0;
        end else begin
            ireq_r  <= ireq_nxt;
            istat_r <= istat_nxt;
            if (reg_wr) begin
                case (reg_addr)
                    `VIU_ADDR_SLM:   slm_r <= reg_wdata[`VIU_SLM_WIDTH-1:0];
                    `VIU_ADDR_PRA:   pra_r <= reg_wdata;
                    `VIU_ADDR_IERC:  ien_r <= reg_wdata[`VIU_NSRC-1:0];
                    `VIU_ADDR_IMASK: imask_r <= reg_wdata[3:0];
                    default: ;
                endcase
            end
            // break is unmaskable by enables and also ignores the disable flag
            if (software_break_op) begin
                brk_pend_r <= 1'b1;
            end else if (accept && !rst_pend_r && src_sel == `VIU_SRC_NONE) begin
                brk_pend_r <= 1'b0; // only when break itself is the one taken
            end
            core_push        <= 1'b0;
            core_set_disable <= 1'b0;
            if (accept) begin
                core_push        <= ~rst_pend_r;    // reset pushes nothing
                core_set_disable <= 1'b1;
                core_is_reset    <= rst_pend_r;
                core_is_break    <= ~rst_pend_r & brk_pend_r & (src_sel == `VIU_SRC_NONE);
                if (rst_pend_r) begin
                    core_vector <= `VIU_VEC_RESET;
                    rst_pend_r  <= 1'b0;
                end else if (src_sel != `VIU_SRC_NONE) begin
                    core_vector <= vec_of(src_sel);
                end else begin
                    core_vector <= `VIU_VEC_B;      // break shares the lowest vector
                end
            end
        end
    end

    // read data one cycle after the strobe; unmapped reads give zero
    always @(posedge clk_sys) begin
        if (rst) begin
            reg_rdata <= {DW{1'b0}};
        end else if (reg_rd) begin
            case (reg_addr)
                `VIU_ADDR_SLM:   reg_rdata <= {{(DW-`VIU_SLM_WIDTH){1'b0}}, slm_r};
                `VIU_ADDR_PRA:   reg_rdata <= pra_r;
                `VIU_ADDR_IERC:  reg_rdata <= {ireq_r[4], ireq_r[3], ireq_r[1],
                                               ireq_r[0] | ireq_r[2], 4'h0} | {3'h0, ien_r};
                `VIU_ADDR_ISTAT: reg_rdata <= {4'h0, istat_r};
                `VIU_ADDR_IMASK: reg_rdata <= {4'h0, imask_r};
                default:         reg_rdata <= {DW{1'b0}};
            endcase
        end else begin
            reg_rdata <= {DW{1'b0}};
        end
    end
endmodule
`default_nettype wire

/* sim/vectored_interrupt_unit_tb_top.sv */
// self-checking bench for the vectored interrupt unit
`timescale 1ns/1ns
`default_nettype none
module vectored_interrupt_unit_tb_top;
    logic       clk_sys = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic       ext_a = 1'b1, ext_b = 1'b1; // pins idle high, driven as inputs
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
    logic [5:0] ev = 6'h00; // return, break, serial, timer 2, timer 1, timer x
    wire        core_ack, core_disable_flag, core_irq, core_is_reset, core_is_break;
    wire        core_push, core_set_disable, port_three_serial, irq_out;
    wire [7:0]  reg_rdata;
    wire [15:0] core_vector;
    int         fail_count = 0, checks_done = 0, cyc = 0;
    always #5 clk_sys = ~clk_sys;
    viu_top u_viu_top (.clk_sys, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .ext_irq_a(ext_a), .ext_irq_b(ext_b), .timer_x_zero(ev[0]), .timer_1_zero(ev[1]),
        .timer_2_zero(ev[2]), .serial_cnt_zero(ev[3]), .software_break_op(ev[4]),
        .core_disable_flag, .core_ack, .core_irq, .core_vector, .core_is_reset,
        .core_is_break, .core_push, .core_set_disable, .port_three_serial, .irq_out);
    viu_core_model u_viu_core_model (.clk_sys, .rst, .core_irq, .rti(ev[5]), .core_ack,
        .core_disable_flag);
    task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
        checks_done++;
        if (s !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    // one strobe, w high writes; read data is settled when this returns
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        {reg_addr, reg_wdata, reg_wr, reg_rd} <= {a, d, w, !w};
        @(posedge clk_sys);
        {reg_wr, reg_rd} <= 2'h0;
        #1;
    endtask
    task automatic pulse(input logic [5:0] m);
        @(posedge clk_sys);
        ev <= m;
        @(posedge clk_sys);
        ev <= 6'h00;
    endtask
    // bounded wait for the core to take a request, then the vector
    task automatic acc(input logic [15:0] v);
        int n = 0;
        while (!(core_ack === 1'b1 && core_irq === 1'b1) && n < 40) @(posedge clk_sys) #1 n++;
        @(posedge clk_sys) #1 chk("core_vector", core_vector, v);
    endtask
    task automatic none;
        logic s = 1'b0;
        repeat (12) @(posedge clk_sys) #1 s |= core_ack;
        chk("core_ack", s, 1'b0);
    endtask
    task automatic t_reset_timer;
        acc(16'hFF_FE);
        chk("core_is_reset", core_is_reset, 1'b1);
        bus(1'b1, 8'hFE, 8'hFF);
        pulse(6'h20);
        none;
        pulse(6'h02);
        acc(16'hFF_F8);
        chk("core_push", core_push, 1'b1);
    endtask
    task automatic t_prio;
        pulse(6'h02);
        ext_a <= 1'b0;
        none;
        pulse(6'h20);
        acc(16'hFF_FC);
        pulse(6'h20);
        acc(16'hFF_F8);
        pulse(6'h20);
        none;
    endtask
    task automatic t_mask_link;
        bus(1'b1, 8'hFE, 8'h00);
        pulse(6'h24);
        none;
        bus(1'b1, 8'hFE, 8'hFF);
        acc(16'hFF_F6);
        bus(1'b1, 8'hF5, 8'h04);
        chk("port_three_serial", port_three_serial, 1'b1);
        pulse(6'h24);
        none;
        pulse(6'h08);
        acc(16'hFF_F6);
    endtask
    task automatic t_break_irq;
        pulse(6'h10);
        acc(16'hFF_F4);
        chk("core_is_break", core_is_break, 1'b1);
        bus(1'b1, 8'hF6, 8'h20);
        ext_b <= 1'b0;
        pulse(6'h20);
        ext_b <= 1'b1;
        acc(16'hFF_F4);
        chk("core_is_break", core_is_break, 1'b0);
        bus(1'b1, 8'hE7, 8'h02);
        chk("irq_out", irq_out, 1'b1);
        bus(1'b0, 8'hE6, 8'h00);
        chk("status", reg_rdata[1], 1'b1);
        chk("irq_out", irq_out, 1'b0);
        bus(1'b0, 8'h10, 8'h00);
        chk("unmapped", reg_rdata, 8'h00);
    endtask
    task automatic complete_run;
        if (fail_count == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // hang guard, far above the under 200 cycles the sequence needs
    always @(posedge clk_sys) if (++cyc == 3000) begin
        fail_count++;
        complete_run;
    end
    initial begin
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        t_reset_timer;
        t_prio;
        t_mask_link;
        t_break_irq;
        complete_run;
    end
endmodule
`default_nettype wire

/* sim/viu_core_model.sv */
// core stand-in: takes vectored requests and keeps the disable flag
`timescale 1ns/1ns
`default_nettype none
module viu_core_model (
    input  wire logic clk_sys,
    input  wire logic rst,
    input  wire logic core_irq,
    input  wire logic rti,
    output var  logic core_ack,
    output var  logic core_disable_flag
);
    // ack a cycle after a request, then idle a cycle; flag is up out of reset
    always @(posedge clk_sys) begin
        core_ack <= !rst && core_irq && !core_ack;
        if (rst || (core_ack && core_irq)) core_disable_flag <= 1'b1;
        else if (rti) core_disable_flag <= 1'b0;
    end
endmodule
`default_nettype wire

/* sim/viu_props.sv */
// port checks for the vectored interrupt unit
`timescale 1ns/1ns
`default_nettype none
`include "viu_defines.vh"
module viu_props (
    input wire logic        clk_sys, rst, reg_wr, core_disable_flag, core_ack, core_irq,
    input wire logic        core_is_reset, core_is_break, core_push, port_three_serial,
    input wire logic [7:0]  reg_addr, reg_wdata,
    input wire logic [15:0] core_vector
);
    logic [1:0] sel_r;
    wire        acc = core_ack && core_irq;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    // copy of the source-select bits, since the ports never show them
    always @(posedge clk_sys) begin
        if (rst) sel_r <= 2'h0;
        else if (reg_wr && reg_addr == `VIU_ADDR_SLM) sel_r <= reg_wdata[3:2];
    end
    AST_LINK_PINS: assert property (port_three_serial == (sel_r == 2'h1))
        else $error("pin hand-over wrong");
    AST_PUSH_CAUSE: assert property ($rose(core_push) |-> $past(acc))
        else $error("push without accept");
    AST_ACCEPT_PUSH: assert property (acc |=> core_push || core_is_reset)
        else $error("accept without push");
    AST_MASKED_VEC: assert property (acc && core_disable_flag |=>
        core_vector == 16'hFF_FE || core_vector == 16'hFF_F4) else $error("masked taken");
    AST_RESET_FIRST: assert property ($fell(rst) |-> core_irq)
        else $error("reset not pending");
    AST_VEC_RANGE: assert property (acc |=> core_vector[15:4] == 12'hFFF
        && !core_vector[0] && core_vector[3:0] >= 4'h4) else $error("bad vector");
    AST_VEC_HOLD: assert property (!acc |=> $stable(core_vector))
        else $error("vector moved");
    AST_BREAK_VEC: assert property (core_is_break |-> core_vector == 16'hFF_F4)
        else $error("break vector wrong");
    cover property (acc && core_disable_flag);
    cover property (acc && !core_disable_flag);
    cover property (core_is_break && core_push);
endmodule
bind viu_top viu_props u_viu_props (.clk_sys, .rst, .reg_wr, .core_disable_flag, .core_ack,
    .core_irq, .core_is_reset, .core_is_break, .core_push, .port_three_serial, .reg_addr,
    .reg_wdata, .core_vector);
`default_nettype wire
